//--- src/mac_cascade_params.svh
`ifndef MAC_CASCADE_PARAMS_SVH
`define MAC_CASCADE_PARAMS_SVH

// Bus widths on the cascade
`define CASC_OP_W 72
`define CASC_RES_W 48
`define CASC_MUL_W 24

// Operand bus positions within a quad
`define CASC_IDX_A_H 0
`define CASC_IDX_B_H 1
`define CASC_IDX_A_L 2
`define CASC_IDX_B_L 3

// Result buffer shape
`define CASC_FIFO_DEPTH 8
`define CASC_FIFO_AW 3

// Tie-off values driven by the bottom source
`define CASC_RST_OPS 288'h0
`define CASC_RST_RES 48'h0

`endif

//--- src/mac_cascade_pkg.sv
`include "mac_cascade_params.svh"

package mac_cascade_pkg;

  typedef logic [`CASC_OP_W-1:0] op_bus_t;
  typedef logic [`CASC_RES_W-1:0] res_t;
  typedef op_bus_t [3:0] op_quad_t;

  // State of one arithmetic tile
  typedef struct packed {
    op_quad_t dly_ops;
    res_t dly_res;
    logic dly_valid;
    op_quad_t ops;
    res_t casc_res;
    logic casc_use;
    logic casc_sub;
    logic ops_valid;
    res_t sum;
    logic sum_valid;
  } tile_state_t;

  // State of the feeding end below a tile
  typedef struct packed {
    op_quad_t ops;
    res_t dout;
    logic valid;
    logic usable;
  } source_state_t;

endpackage : mac_cascade_pkg

//--- src/mac_cascade_if.sv
`timescale 1ns/1ps
`default_nettype none

// Upward cascade between a tile and the party directly below it
interface mac_cascade_if;
  mac_cascade_pkg::op_quad_t ops;
  mac_cascade_pkg::res_t dout;
  logic valid;
  logic ready;

  // Receiving tile above
  modport upper (input ops, input dout, input valid, output ready);
  // Feeding party below
  modport lower (output ops, output dout, output valid, input ready);
endinterface : mac_cascade_if

`default_nettype wire

//--- src/mac_cascade_tile.sv
// What this block does
// [RULE1] Accept four 72-bit operand cascades from below
// [RULE2] Forward multiplier operand buses to tile above
// [RULE3] Cascade operand selectable per operand input mux
// [RULE4] Drive 48-bit result upward on cascade
// [RULE5] Add or subtract cascaded result into sum
// [RULE6] Cascade inputs come only from tile below
// [RULE7] Cascade outputs go only to tile above
// [RULE8] User never skips a tile in chain
// [RULE9] Lowest tile inputs tied off, not logic
// [RULE10] Top outputs unused, never consumed by logic
// [RULE11] Delay registers add one cycle per tile
// [RULE12] Staggered B operands give staggered results
// [RULE13] Bottom tile never selects floating cascade inputs
`timescale 1ns/1ps
`default_nettype none

`include "mac_cascade_params.svh"

// Result buffer with valid and ready on both sides
module mac_result_fifo #(
  parameter int WIDTH = `CASC_RES_W,
  parameter int DEPTH = `CASC_FIFO_DEPTH,
  parameter int AW = `CASC_FIFO_AW
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
    logic ready;
    logic valid;
    logic [WIDTH-1:0] head;
  } fifo_state_t;

  fifo_state_t st_q;
  fifo_state_t st_d;
  logic push;
  logic pop;

  // Pointer, count and flag update
  always_comb
  begin
    st_d = st_q;
    push = i_in_valid && st_q.ready;
    pop = i_out_ready && st_q.valid;
    if (push)
    begin
      st_d.mem[st_q.wr] = i_in_data;
      st_d.wr = st_q.wr + 1'b1;
    end
    if (pop)
    begin
      st_d.rd = st_q.rd + 1'b1;
    end
    st_d.cnt = st_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    st_d.ready = st_d.cnt < (AW+1)'(DEPTH);
    st_d.valid = st_d.cnt != '0;
    // Head word kept in a flop so the output needs no read mux
    st_d.head = st_d.mem[st_d.rd];
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_q <= '0;
      st_q.ready <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign o_in_ready = st_q.ready;
  assign o_out_valid = st_q.valid;
  assign o_out_data = st_q.head;
endmodule : mac_result_fifo

// One multiply-accumulate tile, fed by the cascade from below
module mac_cascade_tile (
  input wire logic i_clk,
  input wire logic i_rst,
  mac_cascade_if.upper link,
  input wire logic [3:0] i_sel_link,
  input wire logic i_del_en,
  input wire logic i_casc_use,
  input wire logic i_casc_sub,
  input wire logic i_in_valid,
  input wire mac_cascade_pkg::op_quad_t i_ops,
  output logic o_in_ready,
  output mac_cascade_pkg::op_quad_t o_fwd_ops,
  output mac_cascade_pkg::res_t o_fwd_dout,
  output logic o_fwd_valid,
  output logic o_res_valid,
  input wire logic i_res_ready,
  output mac_cascade_pkg::res_t o_res_data
);
  mac_cascade_pkg::tile_state_t st_q;
  mac_cascade_pkg::tile_state_t st_d;
  mac_cascade_pkg::op_quad_t src_ops;
  mac_cascade_pkg::res_t src_res;
  logic src_valid;
  logic need_link;
  logic adv;
  logic take;
  logic fifo_ready;

  // Signed product of the low operand bits of one multiplier half
  function automatic mac_cascade_pkg::res_t half_prod(
    input mac_cascade_pkg::op_bus_t a,
    input mac_cascade_pkg::op_bus_t b
  );
    logic signed [`CASC_RES_W-1:0] p;
    p = $signed(a[`CASC_MUL_W-1:0]) * $signed(b[`CASC_MUL_W-1:0]);
    return p;
  endfunction : half_prod

  // Pipeline moves only while the result buffer can take a word
  assign adv = fifo_ready;

  // Cascade source: straight from below or through delay stage
  always_comb
  begin
    if (i_del_en)
    begin
      src_ops = st_q.dly_ops; // see [RULE11]
      src_res = st_q.dly_res;
      src_valid = st_q.dly_valid;
    end
    else
    begin
      src_ops = link.ops; // see [RULE1] see [RULE6]
      src_res = link.dout;
      src_valid = link.valid;
    end
  end

  // Operand capture, selection and arithmetic
  always_comb
  begin
    st_d = st_q;
    need_link = (|i_sel_link) || i_casc_use;
    take = adv && i_in_valid && (src_valid || !need_link);
    if (adv)
    begin
      st_d.dly_ops = link.ops; // see [RULE11]
      st_d.dly_res = link.dout;
      st_d.dly_valid = link.valid;
      st_d.ops_valid = take;
      if (take)
      begin
        for (int k = 0; k < 4; k++)
        begin
          st_d.ops[k] = i_sel_link[k] ? src_ops[k] : i_ops[k]; // see [RULE3]
        end
        st_d.casc_res = src_res;
        st_d.casc_use = i_casc_use;
        st_d.casc_sub = i_casc_sub;
      end
      st_d.sum_valid = st_q.ops_valid;
      if (st_q.ops_valid)
      begin
        // Cascaded result joins the sum of both half products
        st_d.sum = half_prod(st_q.ops[`CASC_IDX_A_H], st_q.ops[`CASC_IDX_B_H])
          + half_prod(st_q.ops[`CASC_IDX_A_L], st_q.ops[`CASC_IDX_B_L]);
        if (st_q.casc_use)
        begin
          st_d.sum = st_q.casc_sub ? st_d.sum - st_q.casc_res
            : st_d.sum + st_q.casc_res; // see [RULE5]
        end
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Results drain to the user through the buffer
  mac_result_fifo #(
    .WIDTH(`CASC_RES_W),
    .DEPTH(`CASC_FIFO_DEPTH),
    .AW(`CASC_FIFO_AW)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_in_valid(st_q.sum_valid),
    .o_in_ready(fifo_ready),
    .i_in_data(st_q.sum),
    .o_out_valid(o_res_valid),
    .i_out_ready(i_res_ready),
    .o_out_data(o_res_data)
  );

  // Upward cascade and handshakes
  assign link.ready = fifo_ready;
  assign o_in_ready = fifo_ready;
  assign o_fwd_ops = st_q.ops; // see [RULE2] see [RULE7]
  assign o_fwd_valid = st_q.ops_valid;
  assign o_fwd_dout = st_q.sum; // see [RULE4]
endmodule : mac_cascade_tile

`default_nettype wire

//--- src/mac_cascade_source.sv
`timescale 1ns/1ps
`default_nettype none

`include "mac_cascade_params.svh"

// Party below a tile: a lower tile's outputs or the bottom tie-off
module mac_cascade_source (
  input wire logic i_clk,
  input wire logic i_rst,
  mac_cascade_if.lower link,
  input wire logic i_bottom,
  input wire logic i_valid,
  input wire mac_cascade_pkg::op_quad_t i_ops,
  input wire mac_cascade_pkg::res_t i_dout,
  output logic o_ready,
  output logic o_link_usable
);
  mac_cascade_pkg::source_state_t st_q;
  mac_cascade_pkg::source_state_t st_d;
  logic load;

  // One register stage per tile; staggered B feed staggers results
  always_comb
  begin
    st_d = st_q;
    load = !st_q.valid || link.ready; // see [RULE12]
    st_d.usable = !i_bottom; // see [RULE13]
    if (i_bottom)
    begin
      // Defined tie-off stands in for a floating source
      st_d.ops = `CASC_RST_OPS; // see [RULE9]
      st_d.dout = `CASC_RST_RES;
      st_d.valid = 1'b1;
    end
    else if (load)
    begin
      // Data only from the adjacent lower tile, none skipped
      st_d.ops = i_ops; // see [RULE8]
      st_d.dout = i_dout;
      st_d.valid = i_valid;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Nothing here reads upward outputs of the tile
  assign link.ops = st_q.ops; // see [RULE10]
  assign link.dout = st_q.dout;
  assign link.valid = st_q.valid;
  assign o_ready = (!st_q.valid || link.ready) && !i_bottom;
  assign o_link_usable = st_q.usable;
endmodule : mac_cascade_source

`default_nettype wire

//--- sim/mac_cascade_sva.sv
`timescale 1ns/1ps
`default_nettype none

// Wire-level checks of the upward link
module mac_cascade_sva (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire mac_cascade_pkg::op_quad_t ops,
  input wire mac_cascade_pkg::res_t dout,
  input wire logic valid,
  input wire logic ready
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  // Offered data holds while the tile stalls
  chk_hold_ops:
  assert property (valid && !ready |=> $stable(ops)) else $error("ops moved");
  chk_hold_dout:
  assert property (valid && !ready |=> $stable(dout)) else $error("dout moved");
  chk_hold_valid:
  assert property (valid && !ready |=> valid) else $error("valid dropped");
  // Link state straight after reset, then valid held over a two-cycle stall
  chk_reset_ready:
  assert property ($past(i_rst) |-> ready) else $error("ready low");
  chk_reset_valid:
  assert property ($past(i_rst) |-> !valid) else $error("valid high");
  chk_reset_ops:
  assert property ($past(i_rst) |-> ops == '0) else $error("ops not clear");
  chk_reset_dout:
  assert property ($past(i_rst) |-> dout == '0) else $error("dout not clear");
  chk_stall_span:
  assert property (valid && !ready ##1 !ready |-> valid) else $error("valid lost");
endmodule : mac_cascade_sva

`default_nettype wire

//--- sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic i_clk = 1'h0;
  logic i_rst = 1'h1;
  logic bottom = 1'h0;
  logic src_valid = 1'h0;
  logic [287:0] src_ops = '0;
  logic [47:0] src_dout = '0;
  logic [3:0] sel = 4'h0;
  logic del_en = 1'h0;
  logic casc_use = 1'h0;
  logic casc_sub = 1'h0;
  logic in_valid = 1'h0;
  logic [287:0] ops = '0;
  logic res_ready = 1'h0;
  logic in_ready, fwd_valid, res_valid, usable, src_ready;
  logic [287:0] fwd_ops, q;
  logic [47:0] res_data, c, fwd_dout;
  int fails = 0;
  int check_count = 0;
  int n;
  mac_cascade_if lnk ();

  mac_cascade_source mac_cascade_source_inst (.i_clk(i_clk), .i_rst(i_rst),
    .link(lnk.lower), .i_bottom(bottom), .i_valid(src_valid), .i_ops(src_ops),
    .i_dout(src_dout), .o_ready(src_ready), .o_link_usable(usable));
  mac_cascade_tile mac_cascade_tile_inst (.i_clk(i_clk), .i_rst(i_rst), .link(lnk.upper),
    .i_sel_link(sel), .i_del_en(del_en), .i_casc_use(casc_use), .i_casc_sub(casc_sub),
    .i_in_valid(in_valid), .i_ops(ops), .o_in_ready(in_ready), .o_fwd_ops(fwd_ops),
    .o_fwd_dout(fwd_dout), .o_fwd_valid(fwd_valid), .o_res_valid(res_valid),
    .i_res_ready(res_ready), .o_res_data(res_data));
  mac_cascade_sva mac_cascade_sva_inst (.i_clk(i_clk), .i_rst(i_rst), .ops(lnk.ops),
    .dout(lnk.dout), .valid(lnk.valid), .ready(lnk.ready));

  // Clock of 4 ns
  always #2 i_clk = ~i_clk;

  // Expected sum of both products, cascaded term added or taken away
  function automatic logic [47:0] mac(input logic [287:0] v, input logic [47:0] r,
    input logic u, input logic s);
    logic signed [47:0] p;
    p = $signed(v[23:0]) * $signed(v[95:72]) + $signed(v[167:144]) * $signed(v[239:216]);
    if (u)
      p = s ? p - r : p + r;
    return p;
  endfunction : mac

  task automatic chk(input string name, input logic [287:0] seen, input logic [287:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // Bounded wait ran out
  task automatic lapse(input int k);
    if (k == 50)
    begin
      fails++;
      end_of_test();
    end
  endtask : lapse

  // Offer one operand set until the tile takes it
  task automatic push(input logic [287:0] v);
    int k;
    @(negedge i_clk);
    ops = v;
    in_valid = 1'h1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge i_clk);
      if (in_ready === 1'h1 && (sel == 4'h0 || lnk.valid === 1'h1))
        break;
    end
    lapse(k);
    @(negedge i_clk);
    in_valid = 1'h0;
    chk("fwd_valid", fwd_valid, 1'h1);
  endtask : push

  // Take one result from the buffer
  task automatic pop(input logic [47:0] e);
    int k;
    @(negedge i_clk);
    res_ready = 1'h1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge i_clk);
      if (res_valid === 1'h1)
        break;
    end
    lapse(k);
    chk("res_data", res_data, e);
    @(negedge i_clk);
    res_ready = 1'h0;
  endtask : pop

  // Main sequence
  initial
  begin
    repeat (12) @(negedge i_clk);
    i_rst = 1'h0;
    q = {72'h1000007, 72'h2000011, 72'hfffffd, 72'h5};
    push(q);
    chk("fwd_ops", fwd_ops, q);
    pop(mac(q, '0, 1'h0, 1'h0));
    chk("fwd_dout", fwd_dout, mac(q, '0, 1'h0, 1'h0));
    // Cascaded operands and result, add and subtract, both delay settings
    c = 48'h123456789abc;
    src_ops = ~q;
    src_dout = c;
    src_valid = 1'h1;
    sel = 4'hf;
    casc_use = 1'h1;
    for (n = 0; n < 4; n++)
    begin
      casc_sub = n[0];
      del_en = n[1];
      push(q);
      chk("fwd_ops", fwd_ops, ~q);
      pop(mac(~q, c, 1'h1, n[0]));
      chk("fwd_dout", fwd_dout, mac(~q, c, 1'h1, n[0]));
    end
    // Fill the buffer until refused, then drain in order
    sel = 4'h0;
    casc_use = 1'h0;
    in_valid = 1'h1;
    for (n = 0; n < 20; n++)
    begin
      ops = {144'h0, 72'h3, 72'(n + 1)};
      @(posedge i_clk);
      if (in_ready !== 1'h1)
        break;
      @(negedge i_clk);
    end
    @(negedge i_clk);
    in_valid = 1'h0;
    chk("in_ready", in_ready, 1'h0);
    for (int k = 0; k < n; k++)
      pop(48'(3 * (k + 1)));
    chk("res_valid", res_valid, 1'h0);
    // Bottom position drives the tie-off
    chk("usable", usable, 1'h1);
    chk("src_ready", src_ready, 1'h1);
    bottom = 1'h1;
    repeat (3) @(negedge i_clk);
    chk("usable", usable, 1'h0);
    chk("bottom_ops", lnk.ops, '0);
    chk("src_ready", src_ready, 1'h0);
    end_of_test();
  end
endmodule : testbench

`default_nettype wire
